// File: rtl/ccc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - In done, deliver no charge current while pack stays above recharge threshold.
// - In done, start a new cycle when pack drops below recharge threshold.
// - In voltage regulation, filtered taper to termination level ends charge.
// - Termination adjust input high picks one tenth, low picks one twentieth.
// - Termination detect passes two cascaded filters with separate response times.
// - New cycle on recharge drop, battery insertion, or power-on reset.
// - Pre-charge timer clears at cycle start and runs during pre-charge.
// - Pre-charge timer expiry below pre-charge exit threshold gives fault.
// - Fault clears only by power-on reset or battery replacement.
// - Charge timer clears at cycle start and runs during charge phase.
// - Charge timer expiry before termination gives fault.
// - Status: charging a on, done b on, others both off.
// - Status pins are open drain: on pulls low, off releases.
// - In fault, source removal current; regulation holding means pack removed.
module ccc_ctrl
   import ccc_pkg::*;
#(
   parameter int TICK_CYC_P = TICK_CYC,
   parameter int PRE_TICKS_P = PRE_TICKS,
   parameter int CHG_TICKS_P = CHG_TICKS,
   parameter int FILT_B_CYC_P = FILT_B_CYC
) (
   input wire logic core_clk, // Core clock, 25 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic wb_cyc_i, // Wishbone cycle.
   input wire logic wb_stb_i, // Wishbone strobe.
   input wire logic wb_we_i, // Wishbone write enable.
   input wire logic [ADR_W-1:0] wb_adr_i, // Wishbone byte address.
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
   input wire logic [31:0] wb_dat_i, // Wishbone write data.
   output logic [31:0] wb_dat_o, // Wishbone read data.
   output logic wb_ack_o, // Wishbone acknowledge.
   input wire logic batt_below_recharge, // Pack below recharge_threshold.
   input wire logic batt_above_lowv, // Pack above precharge_exit_threshold.
   input wire logic cur_below_tenth, // Current below one tenth of regulation.
   input wire logic cur_below_twentieth, // Current below one twentieth.
   input wire logic termination_adjust_input, // High when tied to reference.
   input wire logic batt_present, // Battery presence detect.
   input wire logic temp_ok, // Pack temperature in range.
   input wire logic vreg_active, // Voltage regulation loop in control.
   input wire logic removal_hold, // Regulation holds on removal current.
   output logic charge_en, // Charge current enable.
   output logic precharge_en, // Pre-charge regulation select.
   output logic removal_detect_en, // Source removal_detect_current.
   input wire logic status_out_a_in, // Status a pin level.
   output logic status_out_a_out, // Status a drive value.
   output logic status_out_a_oe_n, // Status a enable, low pulls.
   input wire logic status_out_b_in, // Status b pin level.
   output logic status_out_b_out, // Status b drive value.
   output logic status_out_b_oe_n // Status b enable, low pulls.
);
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1_r;
   logic [NPIN-1:0] sync2_r;
   logic present_q_r;
   logic ins_pulse;
   logic por_pend_r;
   logic [TICK_W-1:0] tick_cnt_r;
   logic tick;
   logic [TMR_W-1:0] pre_cnt_r;
   logic [TMR_W-1:0] chg_cnt_r;
   logic pre_exp;
   logic chg_exp;
   logic term_raw;
   logic filt_a;
   logic term_ok;
   ccc_state_t state_r;
   ccc_state_t state_nxt;
   ccc_state_t resume_r;
   ccc_state_t first_st;
   logic start_cycle;
   logic en_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic [31:0] rd_nxt;
   logic charge_en_r;
   logic precharge_en_r;
   logic removal_en_r;
   logic sa_oe_n_r;
   logic sb_oe_n_r;
   logic wb_req;

   assign pin_raw[PIN_RCH] = batt_below_recharge;
   assign pin_raw[PIN_LOWV] = batt_above_lowv;
   assign pin_raw[PIN_TENTH] = cur_below_tenth;
   assign pin_raw[PIN_TWENTIETH] = cur_below_twentieth;
   assign pin_raw[PIN_TERM_ADJ] = termination_adjust_input;
   assign pin_raw[PIN_PRESENT] = batt_present;
   assign pin_raw[PIN_TEMP] = temp_ok;
   assign pin_raw[PIN_VREG] = vreg_active;
   assign pin_raw[PIN_IDHOLD] = removal_hold;
   assign pin_raw[PIN_SA] = status_out_a_in;
   assign pin_raw[PIN_SB] = status_out_b_in;

   // Two-stage synchroniser for every pin input.
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= pin_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   // Battery insertion edge and the pending power-on start.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         present_q_r <= 1'b0;
         por_pend_r <= 1'b1;
      end else begin
         present_q_r <= sync2_r[PIN_PRESENT];
         if (start_cycle) begin
            por_pend_r <= 1'b0;
         end
      end
   end
   assign ins_pulse = sync2_r[PIN_PRESENT] & ~present_q_r;

   // Fixed reference tick that paces both safety timers.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tick_cnt_r <= '0;
      end else if (tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
      end
   end
   assign tick = (tick_cnt_r == TICK_W'(TICK_CYC_P - 1));

   // Pre-charge safety timer.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pre_cnt_r <= '0;
      end else if (start_cycle) begin
         pre_cnt_r <= '0;
      end else if (state_r == st_pre && tick && !pre_exp) begin
         pre_cnt_r <= pre_cnt_r + 1'b1;
      end
   end
   assign pre_exp = (pre_cnt_r >= TMR_W'(PRE_TICKS_P));

   // Charge safety timer.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         chg_cnt_r <= '0;
      end else if (start_cycle) begin
         chg_cnt_r <= '0;
      end else if (state_r == st_fast && tick && !chg_exp) begin
         chg_cnt_r <= chg_cnt_r + 1'b1;
      end
   end
   assign chg_exp = (chg_cnt_r >= TMR_W'(CHG_TICKS_P));

   // Termination level select and the two-stage noise filter.
   assign term_raw = (sync2_r[PIN_TERM_ADJ] ? sync2_r[PIN_TENTH] : sync2_r[PIN_TWENTIETH])
      & sync2_r[PIN_VREG] & (state_r == st_fast);
   ccc_filt #(.HOLD_CYC(FILT_A_CYC)) u_filt_a (
      .core_clk(core_clk),
      .rst(rst),
      .din(term_raw),
      .q_r(filt_a)
   );
   ccc_filt #(.HOLD_CYC(FILT_B_CYC_P)) u_filt_b (
      .core_clk(core_clk),
      .rst(rst),
      .din(filt_a & term_raw),
      .q_r(term_ok)
   );

   // Start of a new cycle and its first phase.
   always_comb begin
      first_st = sync2_r[PIN_LOWV] ? st_fast : st_pre;
      start_cycle = 1'b0;
      case (state_r)
         st_absent: start_cycle = en_r & sync2_r[PIN_PRESENT] & (ins_pulse | por_pend_r);
         st_done: start_cycle = en_r & (sync2_r[PIN_RCH] | ins_pulse);
         st_fault: start_cycle = en_r & ins_pulse;
         default: start_cycle = 1'b0;
      endcase
   end

   // Charge-cycle next state.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_absent: begin
            if (start_cycle) begin
               state_nxt = first_st;
            end
         end
         st_pre: begin
            if (!sync2_r[PIN_PRESENT]) begin
               state_nxt = st_absent;
            end else if (sync2_r[PIN_LOWV]) begin
               state_nxt = st_fast;
            end else if (pre_exp) begin
               state_nxt = st_fault;
            end else if (!sync2_r[PIN_TEMP]) begin
               state_nxt = st_suspend;
            end
         end
         st_fast: begin
            if (!sync2_r[PIN_PRESENT]) begin
               state_nxt = st_absent;
            end else if (term_ok) begin
               state_nxt = st_done;
            end else if (chg_exp) begin
               state_nxt = st_fault;
            end else if (!sync2_r[PIN_TEMP]) begin
               state_nxt = st_suspend;
            end
         end
         st_suspend: begin
            if (!sync2_r[PIN_PRESENT]) begin
               state_nxt = st_absent;
            end else if (sync2_r[PIN_TEMP]) begin
               state_nxt = resume_r;
            end
         end
         st_done: begin
            if (start_cycle) begin
               state_nxt = first_st;
            end
         end
         st_fault: begin
            if (start_cycle) begin
               state_nxt = first_st;
            end else if (ins_pulse || sync2_r[PIN_IDHOLD]) begin
               state_nxt = st_absent;
            end
         end
         default: state_nxt = st_absent;
      endcase
   end

   // State register and the phase to resume after a temperature hold.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= st_absent;
         resume_r <= st_pre;
      end else begin
         state_r <= state_nxt;
         if (state_nxt == st_suspend && state_r != st_suspend) begin
            resume_r <= state_r;
         end
      end
   end

   // Outputs decoded from the next state so they change cleanly with it.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         charge_en_r <= 1'b0;
         precharge_en_r <= 1'b0;
         removal_en_r <= 1'b0;
         sa_oe_n_r <= 1'b1;
         sb_oe_n_r <= 1'b1;
      end else begin
         charge_en_r <= (state_nxt == st_pre) || (state_nxt == st_fast);
         precharge_en_r <= (state_nxt == st_pre);
         removal_en_r <= (state_nxt == st_fault);
         sa_oe_n_r <= !((state_nxt == st_pre) || (state_nxt == st_fast));
         sb_oe_n_r <= !(state_nxt == st_done);
      end
   end
   assign charge_en = charge_en_r;
   assign precharge_en = precharge_en_r;
   assign removal_detect_en = removal_en_r;
   assign status_out_a_out = OD_LOW;
   assign status_out_b_out = OD_LOW;
   assign status_out_a_oe_n = sa_oe_n_r;
   assign status_out_b_oe_n = sb_oe_n_r;

   // Wishbone slave: one wait state, unmapped reads return zero.
   assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
   always_comb begin
      rd_nxt = '0;
      if (wb_adr_i == ADR_CTRL) begin
         rd_nxt[CTRL_EN_BIT] = en_r;
      end else if (wb_adr_i == ADR_STATUS) begin
         rd_nxt[ST_STATE_LSB +: 3] = state_r;
         rd_nxt[ST_CHG_BIT] = charge_en_r;
         rd_nxt[ST_REM_BIT] = removal_en_r;
         rd_nxt[ST_TERM_ADJ_BIT] = sync2_r[PIN_TERM_ADJ];
         rd_nxt[ST_SA_BIT] = sync2_r[PIN_SA];
         rd_nxt[ST_SB_BIT] = sync2_r[PIN_SB];
         rd_nxt[ST_FAULT_BIT] = (state_r == st_fault);
      end else if (wb_adr_i == ADR_PRE_TMR) begin
         rd_nxt[TMR_W-1:0] = pre_cnt_r;
      end else if (wb_adr_i == ADR_CHG_TMR) begin
         rd_nxt[TMR_W-1:0] = chg_cnt_r;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
         dat_r <= '0;
      end else begin
         ack_r <= wb_req;
         if (wb_req && !wb_we_i) begin
            dat_r <= rd_nxt;
         end
      end
   end

   // Control register: the enable gates every new cycle.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         en_r <= CTRL_EN_RST;
      end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
         en_r <= wb_dat_i[CTRL_EN_BIT];
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   a_done_no_current: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == st_done) |-> (!charge_en && status_out_b_oe_n == 1'b0))
      else $error("charge current or status wrong in done");
   a_done_recharge: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == st_done && en_r && sync2_r[PIN_RCH])
      |=> (state_r inside {st_pre, st_fast}) ##1 charge_en)
      else $error("recharge did not restart charging");
   a_term_to_done: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == st_fast && sync2_r[PIN_PRESENT] && term_ok) |=> (state_r == st_done))
      else $error("termination did not end charge");
   a_term_filtered: assert property (@(posedge core_clk) disable iff (rst)
      $rose(term_ok) |-> $past(term_raw) && $past(filt_a) && $past(term_raw, 2))
      else $error("termination not filtered");
   a_pre_timer_clear: assert property (@(posedge core_clk) disable iff (rst)
      start_cycle |=> (pre_cnt_r == '0 && chg_cnt_r == '0))
      else $error("timers not cleared at cycle start");
   a_pre_fault: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == st_pre && pre_exp && sync2_r[PIN_PRESENT] && !sync2_r[PIN_LOWV])
      |=> (state_r == st_fault) ##1 (sa_oe_n_r && sb_oe_n_r))
      else $error("pre-charge expiry did not fault");
   a_fault_latched: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == st_fault && !ins_pulse && !sync2_r[PIN_IDHOLD]) |=> (state_r == st_fault))
      else $error("fault left without replacement");
   a_chg_timer_run: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == st_fast && tick && !chg_exp && !start_cycle)
      |=> (chg_cnt_r == $past(chg_cnt_r) + 1'b1))
      else $error("charge timer did not advance");
   a_chg_fault: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == st_fast && chg_exp && !term_ok && sync2_r[PIN_PRESENT]) |=> (state_r == st_fault))
      else $error("charge expiry did not fault");
   a_status_code: assert property (@(posedge core_clk) disable iff (rst)
      (state_r inside {st_pre, st_fast}) |-> (!status_out_a_oe_n && status_out_b_oe_n))
      else $error("charging status code wrong");
   a_open_drain: assert property (@(posedge core_clk) disable iff (rst)
      (status_out_a_out == 1'b0) && (status_out_b_out == 1'b0))
      else $error("status pin drives high");
   a_removal_src: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == st_fault && !ins_pulse && sync2_r[PIN_IDHOLD])
      |=> (state_r == st_absent) ##1 !removal_detect_en)
      else $error("removal detect not handled");
endmodule
`default_nettype wire

// File: rtl/ccc_pkg.sv
package ccc_pkg;
   // Core clock period.
   localparam int CLK_PERIOD_NS = 40;
   // Reference tick for the safety timers and its period in cycles.
   localparam int TICK_TIME_MS = 1;
   localparam int TICK_CYC = (TICK_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_W = 15;
   // Safety timer lengths, in their own units and in reference ticks.
   localparam int PRE_TIME_MIN = 30;
   localparam int CHG_TIME_HR = 5;
   localparam int PRE_TICKS = PRE_TIME_MIN * 60 * 1000 / TICK_TIME_MS;
   localparam int CHG_TICKS = CHG_TIME_HR * 60 * 60 * 1000 / TICK_TIME_MS;
   localparam int TMR_W = 25;
   // Termination filter response times and their cycle counts.
   localparam int FILT_A_NS = 100000;
   localparam int FILT_B_NS = 2000000;
   localparam int FILT_A_CYC = (FILT_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_B_CYC = (FILT_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_W = 16;
   // Positions of the pin inputs in the synchroniser vector.
   localparam int PIN_RCH = 0;
   localparam int PIN_LOWV = 1;
   localparam int PIN_TENTH = 2;
   localparam int PIN_TWENTIETH = 3;
   localparam int PIN_TERM_ADJ = 4;
   localparam int PIN_PRESENT = 5;
   localparam int PIN_TEMP = 6;
   localparam int PIN_VREG = 7;
   localparam int PIN_IDHOLD = 8;
   localparam int PIN_SA = 9;
   localparam int PIN_SB = 10;
   localparam int NPIN = 11;
   // Register map, byte addresses.
   localparam int ADR_W = 4;
   localparam logic [ADR_W-1:0] ADR_CTRL = 4'h0;
   localparam logic [ADR_W-1:0] ADR_STATUS = 4'h4;
   localparam logic [ADR_W-1:0] ADR_PRE_TMR = 4'h8;
   localparam logic [ADR_W-1:0] ADR_CHG_TMR = 4'hc;
   // Control register fields and reset value.
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   // Status register fields.
   localparam int ST_STATE_LSB = 0;
   localparam int ST_CHG_BIT = 3;
   localparam int ST_REM_BIT = 4;
   localparam int ST_TERM_ADJ_BIT = 5;
   localparam int ST_SA_BIT = 6;
   localparam int ST_SB_BIT = 7;
   localparam int ST_FAULT_BIT = 8;
   // Open-drain pins only ever pull low.
   localparam logic OD_LOW = 1'b0;
   // Charge-cycle states.
   typedef enum logic [2:0] {
      st_absent,
      st_pre,
      st_fast,
      st_suspend,
      st_done,
      st_fault
   } ccc_state_t;
endpackage

// File: rtl/ccc_filt.sv
`timescale 1ns/1ps
`default_nettype none
module ccc_filt
   import ccc_pkg::*;
#(
   parameter int HOLD_CYC = 1
) (
   input wire logic core_clk, // Core clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic din, // Raw detect level.
   output logic q_r // Detect level, held for HOLD_CYC cycles.
);
   logic [FILT_W-1:0] cnt_r;

   // Count consecutive high cycles; any low cycle restarts the count.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         q_r <= 1'b0;
      end else if (!din) begin
         cnt_r <= '0;
         q_r <= 1'b0;
      end else if (cnt_r >= FILT_W'(HOLD_CYC - 1)) begin
         q_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: dv/ccc_pack.sv
`timescale 1ns/1ps
`default_nettype none
// Pack model. Level 0 is deep, 1 is mid, 2 is full; taper 0 is high, 1 is under a tenth, 2 under a twentieth.
module ccc_pack (
   input wire logic core_clk, // Core clock.
   input wire logic inserted, // Pack sits in the cradle.
   input wire logic [1:0] lvl, // Pack voltage level.
   input wire logic [1:0] taper, // Charge current taper.
   input wire logic rem_en, // Removal current is sourced.
   input wire logic a_oe_n, // Status a enable, low pulls.
   input wire logic b_oe_n, // Status b enable, low pulls.
   output logic present, // Presence detect.
   output logic below_rch, // Pack below recharge_threshold.
   output logic above_lowv, // Pack above precharge_exit_threshold.
   output logic below_tenth, // Current under one tenth.
   output logic below_twentieth, // Current under one twentieth.
   output logic vreg, // Voltage loop in control.
   output logic id_hold, // Regulation holds on removal current alone.
   output logic pin_a, // Status a wire.
   output logic pin_b // Status b wire.
);
   // Comparators start from an empty cradle at time zero.
   initial begin
      {present, below_rch, above_lowv, below_tenth, below_twentieth, vreg, id_hold} = 7'h20;
   end
   // Comparator results settle just after a clock edge; an empty cradle reads as a low pack.
   always @(posedge core_clk) begin
      present <= inserted;
      below_rch <= !inserted || lvl != 2'h2;
      above_lowv <= inserted && lvl != 2'h0;
      vreg <= inserted && lvl == 2'h2;
      below_tenth <= inserted && taper != 2'h0;
      below_twentieth <= inserted && taper == 2'h2;
      id_hold <= rem_en && !inserted;
   end
   // A released wire rises to its pull-up, a driven one sits low.
   assign pin_a = a_oe_n ? 1'b1 : 1'b0;
   assign pin_b = b_oe_n ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ccc_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [ADR_W-1:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, chg, pre, rem, a_out, a_oe_n, b_out, b_oe_n;
   logic inserted = 1'b1;
   logic [1:0] lvl = 2'h0;
   logic [1:0] taper = 2'h0;
   logic adj_sel = 1'b1;
   logic temp_ok = 1'b1;
   logic present, below_rch, above_lowv, below_tenth, below_twentieth, vreg, id_hold, pin_a, pin_b;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc_cnt = 0;
   // The core clock runs at 25 MHz.
   always #20 core_clk = ~core_clk;
   ccc_ctrl #(.TICK_CYC_P(4), .PRE_TICKS_P(10), .CHG_TICKS_P(1500), .FILT_B_CYC_P(5)) DUT (
      .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .batt_below_recharge(below_rch), .batt_above_lowv(above_lowv),
      .cur_below_tenth(below_tenth), .cur_below_twentieth(below_twentieth),
      .termination_adjust_input(adj_sel), .batt_present(present), .temp_ok(temp_ok),
      .vreg_active(vreg), .removal_hold(id_hold), .charge_en(chg), .precharge_en(pre),
      .removal_detect_en(rem), .status_out_a_in(pin_a), .status_out_a_out(a_out),
      .status_out_a_oe_n(a_oe_n), .status_out_b_in(pin_b), .status_out_b_out(b_out),
      .status_out_b_oe_n(b_oe_n));
   ccc_pack pack (
      .core_clk(core_clk), .inserted(inserted), .lvl(lvl), .taper(taper), .rem_en(rem),
      .a_oe_n(a_oe_n), .b_oe_n(b_oe_n), .present(present), .below_rch(below_rch),
      .above_lowv(above_lowv), .below_tenth(below_tenth), .below_twentieth(below_twentieth),
      .vreg(vreg), .id_hold(id_hold), .pin_a(pin_a), .pin_b(pin_b));
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Compares one value and counts a mismatch.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic Wishbone cycle, held until ack is sampled high.
   task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      chk(32'(ack), 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // Polls the state field until it matches or the poll limit runs out.
   task automatic wait_st(input ccc_state_t st, input int lim);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         wb(1'b0, ADR_STATUS, 32'h0, q);
         n++;
      end while (q[2:0] !== 3'(st) && n < lim);
      chk(32'(q[2:0]), 32'(st));
   endtask
   // Lets a number of cycles pass, then expects the state unchanged.
   task automatic stay(input ccc_state_t st, input int n);
      repeat (n) @(posedge core_clk);
      wait_st(st, 1);
   endtask
   // Checks the resolved status wires, a then b.
   task automatic pins(input logic [1:0] exp);
      chk({30'h0, pin_a, pin_b}, {30'h0, exp});
   endtask
   // Register defaults and the power-on start.
   task automatic t_por();
      logic [31:0] q;
      wb(1'b0, ADR_CTRL, 32'h0, q);
      chk(q, 32'h1);
      wb(1'b1, 4'h1, 32'hffffffff, q);
      wb(1'b0, 4'h1, 32'h0, q);
      chk(q, 32'h0);
      wait_st(st_pre, 10);
      pins(2'b01);
      chk({30'h0, a_out, b_out}, 32'h0);
      chk(32'(pre), 32'h1);
   endtask
   // Temperature suspend, then pre-charge expiry and the latched fault.
   task automatic t_pre_fault();
      temp_ok <= 1'b0;
      wait_st(st_suspend, 10);
      pins(2'b11);
      temp_ok <= 1'b1;
      wait_st(st_pre, 10);
      wait_st(st_fault, 30);
      pins(2'b11);
      chk(32'(rem), 32'h1);
      stay(st_fault, 200);
      inserted <= 1'b0;
      wait_st(st_absent, 10);
      lvl <= 2'h1;
      inserted <= 1'b1;
      wait_st(st_fast, 10);
   endtask
   // Filtered taper at one tenth, with a noise dropout mid-filter.
   task automatic t_term();
      lvl <= 2'h2;
      taper <= 2'h1;
      stay(st_fast, 1500);
      taper <= 2'h0;
      repeat (10) @(posedge core_clk);
      taper <= 2'h1;
      stay(st_fast, 2400);
      wait_st(st_done, 60);
      chk(32'(chg), 32'h0);
      pins(2'b10);
      stay(st_done, 300);
   endtask
   // Recharge starts a fresh cycle; the twentieth level then needs a deeper taper.
   task automatic t_recharge();
      lvl <= 2'h1;
      wait_st(st_fast, 10);
      lvl <= 2'h2;
      adj_sel <= 1'b0;
      stay(st_fast, 2800);
      taper <= 2'h2;
      wait_st(st_done, 1000);
   endtask
   // Charge timer expiry, then a disabled start and the re-enabled one.
   task automatic t_chg_fault();
      logic [31:0] q;
      lvl <= 2'h1;
      taper <= 2'h0;
      wait_st(st_fast, 10);
      stay(st_fast, 5500);
      wait_st(st_fault, 300);
      wb(1'b1, ADR_CTRL, 32'h0, q);
      inserted <= 1'b0;
      wait_st(st_absent, 10);
      inserted <= 1'b1;
      stay(st_absent, 100);
      wb(1'b1, ADR_CTRL, 32'h1, q);
      inserted <= 1'b0;
      repeat (10) @(posedge core_clk);
      inserted <= 1'b1;
      wait_st(st_fast, 10);
   endtask
   // Cuts a hung run short.
   always @(posedge core_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 40000) begin
         error_cnt++;
         $display("wrong value at %0t: run timed out", $time);
         print_verdict();
      end
   end
   // Main sequence.
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      t_por();
      t_pre_fault();
      t_term();
      t_recharge();
      t_chg_fault();
      print_verdict();
   end
endmodule
`default_nettype wire
